/* verilog/cpc_protect_regs.sv */
// ahb-lite register file and desaturation logic of the converter protection block
`timescale 1ns/1ps
module cpc_protect_regs (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic desat_comp_raw,
    input wire logic desat_watchdog,
    input wire logic primary_turn_on,
    input wire logic current_sense_trip,
    output cpc_pkg::cpc_cfg_s analog_cfg,
    output logic desat_to_pwm,
    output logic watchdog_pwm_reset,
    output logic current_trip_blanked,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////////////
    cpc_pkg::cpc_state_s st_r;
    cpc_pkg::cpc_state_s st_nxt;
    logic comp_sync;
    logic desat_status;
    logic rise_evt;
    logic fall_evt;
    logic desat_evt;
    logic accept;
    logic [7:0] wr_byte;

    ////////////////////////////////////////////////////////////////////////////////
    cpc_sync2 u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in(desat_comp_raw),
        .sync_out(comp_sync)
    );

    cpc_blank_timer u_blank (
        .clk_sys(clk_sys),
        .rst(rst),
        .turn_on(primary_turn_on),
        .blanking_code(st_r.blank[1:0]),
        .sense_in(current_sense_trip),
        .sense_out(current_trip_blanked)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // read view of one register; unmapped words read zero
    function automatic logic [7:0] rd_byte(
        input cpc_pkg::cpc_state_s s,
        input logic stat
    );
        logic [7:0] d;
        d = 8'h00;
        if (s.idx == cpc_pkg::IDX_OVL) begin
            d = s.ovl;
        end else if (s.idx == cpc_pkg::IDX_DESAT) begin
            d = s.ds_ctrl & cpc_pkg::DESAT_WR_MASK;
            d[cpc_pkg::DS_STAT_BIT] = stat;
        end else if (s.idx == cpc_pkg::IDX_OFS) begin
            d = s.ofs & cpc_pkg::OFS_MASK;
        end else if (s.idx == cpc_pkg::IDX_BLANK) begin
            d = s.blank & cpc_pkg::BLANK_MASK;
        end else if (s.idx == cpc_pkg::IDX_SLOPE) begin
            d = s.slope & cpc_pkg::SLOPE_MASK;
        end else if (s.idx == cpc_pkg::IDX_TRIM) begin
            d = s.trim;
        end else if (s.idx == cpc_pkg::IDX_IRQ_STAT) begin
            d = s.irq_stat;
        end else if (s.idx == cpc_pkg::IDX_IRQ_MASK) begin
            d = s.irq_mask;
        end
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt = st_r;
        wr_byte = hwdata[7:0];
        accept = hsel && hready && (htrans == cpc_pkg::HTRANS_NONSEQ);

        // status is the synchronised comparator after polarity
        desat_status = comp_sync ^ st_r.ds_ctrl[cpc_pkg::DS_POL_BIT];
        rise_evt = desat_status && !st_r.status_prev;
        fall_evt = !desat_status && st_r.status_prev;
        // output enable deliberately not part of the event term
        desat_evt = (rise_evt && st_r.ds_ctrl[cpc_pkg::DS_RISE_BIT])
            || (fall_evt && st_r.ds_ctrl[cpc_pkg::DS_FALL_BIT]);
        st_nxt.status_prev = desat_status;

        unique case (st_r.phase)
            cpc_pkg::PH_IDLE: begin
            end
            cpc_pkg::PH_WRITE: begin
                if (st_r.idx == cpc_pkg::IDX_OVL) begin
                    st_nxt.ovl = wr_byte;
                end else if (st_r.idx == cpc_pkg::IDX_DESAT) begin
                    st_nxt.ds_ctrl = wr_byte & cpc_pkg::DESAT_WR_MASK;
                end else if (st_r.idx == cpc_pkg::IDX_OFS) begin
                    st_nxt.ofs = wr_byte & cpc_pkg::OFS_MASK;
                end else if (st_r.idx == cpc_pkg::IDX_BLANK) begin
                    st_nxt.blank = wr_byte & cpc_pkg::BLANK_MASK;
                end else if (st_r.idx == cpc_pkg::IDX_SLOPE) begin
                    st_nxt.slope = wr_byte & cpc_pkg::SLOPE_MASK;
                end else if (st_r.idx == cpc_pkg::IDX_TRIM) begin
                    st_nxt.trim = wr_byte;
                end else if (st_r.idx == cpc_pkg::IDX_IRQ_STAT) begin
                    st_nxt.irq_stat = st_r.irq_stat & ~wr_byte;
                end else if (st_r.idx == cpc_pkg::IDX_IRQ_MASK) begin
                    st_nxt.irq_mask = wr_byte & cpc_pkg::IRQ_MASK_BITS;
                end
            end
            cpc_pkg::PH_READ: begin
                // wait state lets a read right after a write see it
                st_nxt.hrdata = {24'h00_0000, rd_byte(st_r, desat_status)};
            end
            cpc_pkg::PH_RDONE: begin
            end
        endcase

        // a set in the same cycle as a clear wins
        if (desat_evt) begin
            st_nxt.irq_stat[cpc_pkg::IRQ_DESAT_BIT] = 1'b1;
        end

        if (st_r.phase == cpc_pkg::PH_READ) begin
            st_nxt.phase = cpc_pkg::PH_RDONE;
        end else if (accept) begin
            st_nxt.idx = haddr[31:2];
            st_nxt.phase = hwrite ? cpc_pkg::PH_WRITE : cpc_pkg::PH_READ;
        end else begin
            st_nxt.phase = cpc_pkg::PH_IDLE;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign hreadyout = (st_r.phase != cpc_pkg::PH_READ);
    assign hrdata = st_r.hrdata;
    assign hresp = 1'b0;
    assign irq = |(st_r.irq_stat & st_r.irq_mask);

    // comparator only reaches the pwm while enabled
    assign desat_to_pwm = desat_status && st_r.ds_ctrl[cpc_pkg::DS_OE_BIT];
    assign watchdog_pwm_reset = desat_watchdog && st_r.ds_ctrl[cpc_pkg::DS_WDE_BIT];

    // codes go to the dacs; the analog side does the scaling
    always_comb begin
        analog_cfg.ov_level_code = st_r.ovl;
        analog_cfg.desat_input_select = st_r.ds_ctrl[cpc_pkg::DS_MUX_BIT];
        analog_cfg.desat_offset_trim = st_r.trim;
        analog_cfg.current_offset_code = st_r.ofs[3:0];
        analog_cfg.blanking_code = st_r.blank[1:0];
        analog_cfg.slope_bypass = st_r.slope[cpc_pkg::SLOPE_BYP_BIT];
        analog_cfg.slope_rate_code = st_r.slope[5:0];
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    AST_MUX_WRITE: assert property (
        (st_r.phase == cpc_pkg::PH_WRITE && st_r.idx == cpc_pkg::IDX_DESAT)
        |=> analog_cfg.desat_input_select == $past(hwdata[7]))
        else $error("input select not taken from write");

    AST_WDOG_GATE: assert property (
        (desat_watchdog && !st_r.ds_ctrl[cpc_pkg::DS_WDE_BIT]) |-> !watchdog_pwm_reset)
        else $error("watchdog reset pwm while disabled");

    AST_POL_INVERT: assert property (
        st_r.ds_ctrl[cpc_pkg::DS_POL_BIT] |-> (desat_status != comp_sync))
        else $error("polarity set but status not inverted");

    AST_OE_BLOCK: assert property (
        !st_r.ds_ctrl[cpc_pkg::DS_OE_BIT] |-> !desat_to_pwm)
        else $error("comparator reached pwm while disabled");

    AST_STATUS_READ: assert property (
        (st_r.phase == cpc_pkg::PH_READ && st_r.idx == cpc_pkg::IDX_DESAT)
        |=> hrdata[2] == $past(desat_status) && hreadyout)
        else $error("status bit read wrong");

    AST_RISE_FLAG: assert property (
        (rise_evt && st_r.ds_ctrl[cpc_pkg::DS_RISE_BIT]) |=> st_r.irq_stat[0])
        else $error("rising edge did not set flag");

    AST_FALL_FLAG: assert property (
        (fall_evt && st_r.ds_ctrl[cpc_pkg::DS_FALL_BIT]) |=> st_r.irq_stat[0])
        else $error("falling edge did not set flag");

    AST_FLAG_CAUSE: assert property (
        $rose(st_r.irq_stat[0]) |-> $past(desat_evt))
        else $error("flag set without enabled edge");

    AST_FLAG_NO_OE: assert property (
        (desat_evt && !st_r.ds_ctrl[cpc_pkg::DS_OE_BIT]) |=> st_r.irq_stat[0])
        else $error("flag depended on output enable");

    AST_UPPER_ZERO: assert property (
        (st_r.phase == cpc_pkg::PH_READ && st_r.idx == cpc_pkg::IDX_OFS)
        |=> hrdata[7:4] == 4'h0)
        else $error("unimplemented bits read nonzero");

    AST_BYPASS_WRITE: assert property (
        (st_r.phase == cpc_pkg::PH_WRITE && st_r.idx == cpc_pkg::IDX_SLOPE)
        |=> analog_cfg.slope_bypass == $past(hwdata[6]) && !st_r.slope[7])
        else $error("slope bypass not written");
endmodule // cpc_protect_regs

/* verilog/cpc_pkg.sv */
// constants, types and register map of the converter protection config block
// What this block does
// - overvoltage code sets reference 2*bandgap*N/255
// - bit 7 picks bandgap or sense pin
// - bit 6 lets watchdog reset the pwm
// - bit 4 inverts the comparator output
// - bit 3 lets comparator act on pwm
// - bit 2 reads comparator after polarity
// - bit 1 flags rising status edges
// - bit 0 flags falling status edges
// - flag sets regardless of output enable
// - 4-bit code adds 0 to 750 mV offset
// - 2-bit code blanks sensing 0/50/100/200 ns
// - bit 6 bypasses slope compensation
// - 6-bit code sets ramp 4.5*1.08^N mV/us
// - unimplemented upper bits read zero, ignore writes
package cpc_pkg;
    ////////////////////////////////////////////////////////////////////////////////
    localparam int CLK_PERIOD_NS = 5;
    localparam int BLANK_T1_NS = 50;
    localparam int BLANK_T2_NS = 100;
    localparam int BLANK_T3_NS = 200;
    localparam int BLANK_C1 = (BLANK_T1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLANK_C2 = (BLANK_T2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLANK_C3 = (BLANK_T3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    ////////////////////////////////////////////////////////////////////////////////
    // word indices; byte address is four times the index
    localparam logic [29:0] IDX_OVL = 30'h0000_0180;
    localparam logic [29:0] IDX_DESAT = 30'h0000_0181;
    localparam logic [29:0] IDX_OFS = 30'h0000_0182;
    localparam logic [29:0] IDX_BLANK = 30'h0000_0183;
    localparam logic [29:0] IDX_SLOPE = 30'h0000_0184;
    localparam logic [29:0] IDX_IRQ_STAT = 30'h0000_0185;
    localparam logic [29:0] IDX_IRQ_MASK = 30'h0000_0186;
    localparam logic [29:0] IDX_TRIM = 30'h0000_0196;
    ////////////////////////////////////////////////////////////////////////////////
    localparam int DS_MUX_BIT = 7;
    localparam int DS_WDE_BIT = 6;
    localparam int DS_POL_BIT = 4;
    localparam int DS_OE_BIT = 3;
    localparam int DS_STAT_BIT = 2;
    localparam int DS_RISE_BIT = 1;
    localparam int DS_FALL_BIT = 0;
    localparam int SLOPE_BYP_BIT = 6;
    localparam int IRQ_DESAT_BIT = 0;
    localparam logic [7:0] DESAT_WR_MASK = 8'hdb;
    localparam logic [7:0] OFS_MASK = 8'h0f;
    localparam logic [7:0] BLANK_MASK = 8'h03;
    localparam logic [7:0] SLOPE_MASK = 8'h7f;
    localparam logic [7:0] IRQ_MASK_BITS = 8'h01;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    ////////////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {PH_IDLE, PH_WRITE, PH_READ, PH_RDONE} cpc_phase_e;

    typedef struct packed {
        logic [7:0] ov_level_code;
        logic desat_input_select;
        logic [7:0] desat_offset_trim;
        logic [3:0] current_offset_code;
        logic [1:0] blanking_code;
        logic slope_bypass;
        logic [5:0] slope_rate_code;
    } cpc_cfg_s;

    typedef struct packed {
        cpc_phase_e phase;
        logic [29:0] idx;
        logic [31:0] hrdata;
        logic [7:0] ovl;
        logic [7:0] ds_ctrl;
        logic [7:0] ofs;
        logic [7:0] blank;
        logic [7:0] slope;
        logic [7:0] trim;
        logic [7:0] irq_stat;
        logic [7:0] irq_mask;
        logic status_prev;
    } cpc_state_s;
endpackage

/* verilog/cpc_sync2.sv */
// two-flop synchroniser for the asynchronous comparator output
`timescale 1ns/1ps
module cpc_sync2 (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic async_in,
    output logic sync_out
);
    typedef struct packed {
        logic meta;
        logic stable;
    } cpc_sync_s;

    cpc_sync_s st_r;
    cpc_sync_s st_nxt;

    always_comb begin
        st_nxt.meta = async_in;
        st_nxt.stable = st_r.meta;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.stable;

    AST_SYNC_DELAY: assert property (@(posedge clk_sys) disable iff (rst)
        ##2 sync_out == $past(async_in, 2)) else $error("sync output not two cycles late");
endmodule // cpc_sync2

/* verilog/cpc_blank_timer.sv */
// turn-on blanking of the primary current sense trip
`timescale 1ns/1ps
module cpc_blank_timer (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic turn_on,
    input wire logic [1:0] blanking_code,
    input wire logic sense_in,
    output logic sense_out
);
    typedef struct packed {
        logic [5:0] cnt;
    } cpc_blank_s;

    cpc_blank_s st_r;
    cpc_blank_s st_nxt;
    logic start;

    // cycles still to blank after the turn-on cycle itself
    function automatic logic [5:0] blank_len(input logic [1:0] code);
        unique case (code)
            2'h0: blank_len = 6'h00;
            2'h1: blank_len = 6'(cpc_pkg::BLANK_C1 - 1);
            2'h2: blank_len = 6'(cpc_pkg::BLANK_C2 - 1);
            2'h3: blank_len = 6'(cpc_pkg::BLANK_C3 - 1);
        endcase
    endfunction

    always_comb begin
        st_nxt = st_r;
        start = turn_on && (blanking_code != 2'h0);
        if (start) begin
            st_nxt.cnt = blank_len(blanking_code);
        end else if (st_r.cnt != 6'h00) begin
            st_nxt.cnt = st_r.cnt - 6'h01;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // a new turn-on restarts the window rather than extending it
    assign sense_out = sense_in && !start && (st_r.cnt == 6'h00);

    AST_BLANK_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
        (turn_on && blanking_code != 2'h0) |-> !sense_out [*8])
        else $error("sense passed inside blanking window");
endmodule // cpc_blank_timer

/* verif/cpc_stage_model.sv */
// behavioural comparator and power stage on the far side of the protection block
`timescale 1ns/1ps
module cpc_stage_model (
    input wire logic clk_sys,
    input wire logic comp_lvl,
    input wire logic wd_lvl,
    input wire logic trip_lvl,
    input wire logic fire,
    output logic desat_comp_raw,
    output logic desat_watchdog,
    output logic primary_turn_on,
    output logic current_sense_trip
);
    initial begin
        desat_comp_raw = 1'b0;
        desat_watchdog = 1'b0;
        primary_turn_on = 1'b0;
        current_sense_trip = 1'b0;
    end
    // comparator is analog: it moves off the clock edge, so the block must synchronise it
    always @(comp_lvl) desat_comp_raw <= #2 comp_lvl;
    ////////////////////////////////////////////////////////////
    // turn-on follows the fire request level, one cycle later
    always @(posedge clk_sys) begin
        desat_watchdog <= wd_lvl;
        current_sense_trip <= trip_lvl;
        primary_turn_on <= fire;
    end
endmodule // cpc_stage_model

/* verif/cpc_protect_regs_tb.sv */
// self-checking bench of the converter protection register block
`timescale 1ns/1ps
module cpc_protect_regs_tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout, hresp, irq, desat_to_pwm, watchdog_pwm_reset, current_trip_blanked;
    logic [31:0] hrdata;
    cpc_pkg::cpc_cfg_s analog_cfg;
    logic desat_comp_raw, desat_watchdog, primary_turn_on, current_sense_trip;
    logic comp_lvl = 1'b0;
    logic wd_lvl = 1'b0;
    logic trip_lvl = 1'b0;
    logic fire = 1'b0;
    int err_count = 0;
    int n_tests = 0;
    logic [31:0] rd;
    // irq status kept last: its write-one-clear wipes the flag raised by the desat write
    logic [29:0] idx_tab [8] = '{cpc_pkg::IDX_OVL, cpc_pkg::IDX_DESAT, cpc_pkg::IDX_OFS,
        cpc_pkg::IDX_BLANK, cpc_pkg::IDX_SLOPE, cpc_pkg::IDX_IRQ_MASK, cpc_pkg::IDX_TRIM,
        cpc_pkg::IDX_IRQ_STAT};
    logic [7:0] msk [8] = '{8'hff, 8'hdf, 8'h0f, 8'h03, 8'h7f, 8'h01, 8'hff, 8'h00};

    always #2.5 clk_sys = ~clk_sys;

    cpc_protect_regs cpc_protect_regs_inst (.clk_sys(clk_sys), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .desat_comp_raw(desat_comp_raw), .desat_watchdog(desat_watchdog),
        .primary_turn_on(primary_turn_on), .current_sense_trip(current_sense_trip),
        .analog_cfg(analog_cfg), .desat_to_pwm(desat_to_pwm),
        .watchdog_pwm_reset(watchdog_pwm_reset), .current_trip_blanked(current_trip_blanked),
        .irq(irq));
    cpc_stage_model cpc_stage_model_inst (.clk_sys(clk_sys), .comp_lvl(comp_lvl),
        .wd_lvl(wd_lvl), .trip_lvl(trip_lvl), .fire(fire), .desat_comp_raw(desat_comp_raw),
        .desat_watchdog(desat_watchdog), .primary_turn_on(primary_turn_on),
        .current_sense_trip(current_sense_trip));
    ////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // sample ready and data at the falling edge, settled before the deciding rising edge
    task automatic wait_rdy();
        logic ok;
        ok = 1'b0;
        for (int i = 0; i < 20 && !ok; i++) begin
            @(negedge clk_sys);
            ok = (hreadyout === 1'b1);
            rd = hrdata;
            @(posedge clk_sys);
        end
        if (!ok) begin
            err_count++;
            print_verdict();
        end
    endtask
    task automatic bus(input logic w, input logic [29:0] idx, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {idx, 2'b00};
        htrans <= cpc_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        if (w) hwdata <= d;
        wait_rdy();
    endtask
    task automatic wr(input logic [29:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d);
    endtask
    task automatic rdchk(input logic [29:0] idx, input logic [31:0] e);
        bus(1'b0, idx, 32'h0000_0000);
        chk(rd, e);
    endtask
    task automatic pchk(ref logic s, input logic e);
        @(negedge clk_sys);
        chk({31'h0, s}, {31'h0, e});
        @(posedge clk_sys);
    endtask
    task automatic comp(input logic v);
        comp_lvl <= v;
        repeat (6) @(posedge clk_sys);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_reset();
        for (int i = 0; i < 8; i++) rdchk(idx_tab[i], 32'h0000_0000);
        chk({2'b00, analog_cfg}, 32'h0000_0000);
        pchk(irq, 1'b0);
        pchk(hresp, 1'b0);
    endtask
    task automatic t_regs();
        for (int i = 0; i < 8; i++) wr(idx_tab[i], 32'hffff_ffff);
        for (int i = 0; i < 8; i++) rdchk(idx_tab[i], {24'h0, msk[i]});
        chk({2'b00, analog_cfg}, 32'h3fff_ffff);
        wr(30'h0000_0187, 32'hffff_ffff);
        rdchk(30'h0000_0187, 32'h0000_0000);
        wr(cpc_pkg::IDX_DESAT, 32'h0000_0000);
        repeat (6) @(posedge clk_sys);
        wr(cpc_pkg::IDX_IRQ_STAT, 32'h0000_0001);
    endtask
    task automatic t_desat();
        wr(cpc_pkg::IDX_DESAT, 32'h0000_0018);
        comp(1'b1);
        rdchk(cpc_pkg::IDX_DESAT, 32'h0000_0018);
        pchk(desat_to_pwm, 1'b0);
        wr(cpc_pkg::IDX_DESAT, 32'h0000_0008);
        repeat (4) @(posedge clk_sys);
        rdchk(cpc_pkg::IDX_DESAT, 32'h0000_000c);
        pchk(desat_to_pwm, 1'b1);
        wr(cpc_pkg::IDX_DESAT, 32'h0000_0000);
        pchk(desat_to_pwm, 1'b0);
        wd_lvl <= 1'b1;
        wr(cpc_pkg::IDX_DESAT, 32'h0000_0040);
        pchk(watchdog_pwm_reset, 1'b1);
        wr(cpc_pkg::IDX_DESAT, 32'h0000_0002);
        pchk(watchdog_pwm_reset, 1'b0);
        comp(1'b0);
        rdchk(cpc_pkg::IDX_IRQ_STAT, 32'h0000_0000);
        comp(1'b1);
        rdchk(cpc_pkg::IDX_IRQ_STAT, 32'h0000_0001);
        pchk(irq, 1'b1);
        wr(cpc_pkg::IDX_IRQ_MASK, 32'h0000_0000);
        pchk(irq, 1'b0);
        wr(cpc_pkg::IDX_IRQ_MASK, 32'h0000_0001);
        wr(cpc_pkg::IDX_IRQ_STAT, 32'h0000_0001);
        repeat (8) @(posedge clk_sys);
        rdchk(cpc_pkg::IDX_IRQ_STAT, 32'h0000_0000);
        wr(cpc_pkg::IDX_DESAT, 32'h0000_0001);
        comp(1'b0);
        rdchk(cpc_pkg::IDX_IRQ_STAT, 32'h0000_0001);
        wr(cpc_pkg::IDX_IRQ_STAT, 32'h0000_0001);
        comp(1'b1);
        rdchk(cpc_pkg::IDX_IRQ_STAT, 32'h0000_0000);
    endtask
    // count low cycles of the blanked trip after one turn-on pulse
    task automatic t_blank();
        int lows;
        trip_lvl <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            wr(cpc_pkg::IDX_BLANK, c);
            fire <= 1'b1;
            @(posedge clk_sys);
            fire <= 1'b0;
            lows = 0;
            repeat (60) begin
                @(negedge clk_sys);
                if (current_trip_blanked !== 1'b1) lows++;
            end
            @(posedge clk_sys);
            chk(lows, c == 0 ? 0 : (50 << (c - 1)) / 5);
        end
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        t_reset();
        t_regs();
        t_desat();
        t_blank();
        print_verdict();
    end
endmodule // cpc_protect_regs_tb
